// ==== pld_lock_regs.svh ====
// Purpose: register map, field positions and timing for the lock detector
// Assumes: register addresses are word indices on the plain register port
// Notes:   definitions only
`ifndef PLD_LOCK_REGS_SVH
`define PLD_LOCK_REGS_SVH
// register indices
`define PLD_A_ENABLE  7'h01
`define PLD_A_PUMP    7'h04
`define PLD_A_OFFSET  7'h05
`define PLD_A_PHASE   7'h06
`define PLD_A_WINDOW  7'h07
`define PLD_A_TESTSEL 7'h08
`define PLD_A_STATUS  7'h12
// general enable fields
`define PLD_EN_WIN    6
`define PLD_EN_PH     7
`define PLD_EN_OUT    8
// pump configuration fields
`define PLD_PUMP_UP   6:0
`define PLD_PUMP_DN   13:7
`define PLD_PUMP_BST  23
// window offset fields
`define PLD_OFS_EN    0
`define PLD_OFS_AFT   1
// phase detector fields
`define PLD_PH_LO     6:0
`define PLD_PH_HI     13:7
`define PLD_PH_OK     23:14
// lock window fields
`define PLD_WIN_SRC   22
`define PLD_WIN_TEST  21
`define PLD_WIN_SPD   20:19
`define PLD_WIN_PW    18:16
`define PLD_WIN_OK    15:0
// status fields
`define PLD_ST_WIN    0
`define PLD_ST_PH     1
`define PLD_ST_LOCK   2
// values
`define PLD_TEST_RING 8'hc1
`define PLD_RST_EN    9'h000
`define PLD_RST_REG   24'h000000
`define PLD_STEP_UA   13'h014
`define PLD_BOOST_UA  13'hdac
// timing in picoseconds
`define PLD_CLK_PS    25000
`define PLD_AWIN_PS   10000
`endif

// ==== pld_pkg.sv ====
// Purpose: types shared by the lock detector and its users
// Assumes: nothing
// Notes:   bus request and pump drive travel as packed structs
package pld_pkg;
   typedef struct packed {
      logic        we;
      logic        re;
      logic [6:0]  addr;
      logic [31:0] wdata;
   } pld_bus_type;
   typedef struct packed {
      logic        boost;
      logic [12:0] up_ua;
      logic [12:0] dn_ua;
   } pld_pump_type;
endpackage

// ==== pld_lock_detector.sv ====
// Purpose: window and phase lock detection with pump current control
// Assumes: reference and divided oscillator edges arrive as async pins
// Notes:   one clock; ring oscillator is a divided clock enable
// Contract
// - boost bit 23 of pump register adds 3.5 mA to programmed pump current.
// - boost works with programmed pump current at zero.
// - window and phase lock detectors enabled by enable field bits 6 and 7; bit 8 enables the lock output.
// - lock indicator shown on test pin and read-only status at 12h.
// - window source clear gives fixed analog window of plus or minus 10 ns; code rounds it up to one 25 ns clock.
// - source set times window by ring periods (18:16) at speed (20:19).
// - bit 21 with test select C1h routes ring to pin, window detector stops.
// - lock after consecutive in-window arrivals equal to count in 15:0.
// - lock sets status bit 2; writes to status do not change it.
// - one out-of-window arrival clears lock and restarts the count.
// - offset bits 0 and 1 set place window after reference edge.
// - offset bit 0 set, bit 1 clear places window before reference.
// - phase error compared against low 6:0 and high 13:7 thresholds.
// - phase lock after error in range for count in bits 23:14.
`timescale 1ns/1ps
`include "pld_lock_regs.svh"
module pld_lock_detector #(
   parameter int CW         = 12, // edge distance counter width
   parameter int OFFSET_CYC = 2   // fixed window offset in cycles
) (
   input  wire logic                 i_clock,    // 40 MHz
   input  wire logic                 i_arst_n,   // async reset
   input  wire pld_pkg::pld_bus_type i_bus,      // register request
   output logic [31:0]               o_rdata,    // read data, next cycle
   input  wire logic                 i_ref_div,  // reference divider
   input  wire logic                 i_vco_div,  // divided oscillator
   output logic                      o_lock,     // lock indicator
   output logic                      o_mp_pin,   // multipurpose pin
   output pld_pkg::pld_pump_type     o_pump      // pump drive
);
   import pld_pkg::*;
   localparam int AWIN_CYC = (`PLD_AWIN_PS / `PLD_CLK_PS < 1) ? 1 :
                             `PLD_AWIN_PS / `PLD_CLK_PS;

   function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] x);
      sat_inc = (&x) ? x : x + 1'b1;
   endfunction

   // registers
   logic [8:0]   en_q, en_d;
   logic [23:0]  pump_q, pump_d, ph_q, ph_d, win_q, win_d;
   logic [1:0]   ofs_q, ofs_d;
   logic [7:0]   sel_q, sel_d;
   logic [31:0]  rdata_q, rdata_d;
   // synchronisers and detection state
   logic         ref_m_q, ref_s_q, ref_p_q, vco_m_q, vco_s_q, vco_p_q;
   logic         ref_rise, vco_rise;
   logic [CW-1:0] sr_q, sr_d, sv_q, sv_d;
   logic         pend_q, pend_d, eval, hit, test, w_act;
   logic [2:0]   ro_cnt_q, ro_cnt_d, ro_pm1;
   logic         ro_q, ro_d, ro_tick;
   logic [15:0]  wcnt_q, wcnt_d;
   logic         wlock_q, wlock_d;
   logic [9:0]   pcnt_q, pcnt_d;
   logic         plock_q, plock_d, p_in;
   logic [6:0]   perr;
   logic         lock_ind, lock_q, mp_q, mp_d;
   pld_pump_type pump_o_q, pump_o_d;
   int           half_i, cen_i, close_i, lo_i, hi_i;

   // register port
   always_comb begin
      en_d    = en_q;
      pump_d  = pump_q;
      ofs_d   = ofs_q;
      ph_d    = ph_q;
      win_d   = win_q;
      sel_d   = sel_q;
      rdata_d = '0;
      if (i_bus.we) begin
         unique case (i_bus.addr)
            `PLD_A_ENABLE:  en_d   = i_bus.wdata[8:0];
            `PLD_A_PUMP:    pump_d = i_bus.wdata[23:0];
            `PLD_A_OFFSET:  ofs_d  = i_bus.wdata[1:0];
            `PLD_A_PHASE:   ph_d   = i_bus.wdata[23:0];
            `PLD_A_WINDOW:  win_d  = i_bus.wdata[23:0];
            `PLD_A_TESTSEL: sel_d  = i_bus.wdata[7:0];
            default: ; // status and unmapped: write ignored
         endcase
      end
      if (i_bus.re) begin
         unique case (i_bus.addr)
            `PLD_A_ENABLE:  rdata_d = {23'h0, en_q};
            `PLD_A_PUMP:    rdata_d = {8'h0, pump_q};
            `PLD_A_OFFSET:  rdata_d = {30'h0, ofs_q};
            `PLD_A_PHASE:   rdata_d = {8'h0, ph_q};
            `PLD_A_WINDOW:  rdata_d = {8'h0, win_q};
            `PLD_A_TESTSEL: rdata_d = {24'h0, sel_q};
            `PLD_A_STATUS: begin
               rdata_d[`PLD_ST_WIN]  = wlock_q;
               rdata_d[`PLD_ST_PH]   = plock_q;
               rdata_d[`PLD_ST_LOCK] = lock_ind;
            end
            default: rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         en_q    <= `PLD_RST_EN;
         pump_q  <= `PLD_RST_REG;
         ofs_q   <= 2'h0;
         ph_q    <= `PLD_RST_REG;
         win_q   <= `PLD_RST_REG;
         sel_q   <= 8'h00;
         rdata_q <= 32'h0;
      end else begin
         en_q    <= en_d;
         pump_q  <= pump_d;
         ofs_q   <= ofs_d;
         ph_q    <= ph_d;
         win_q   <= win_d;
         sel_q   <= sel_d;
         rdata_q <= rdata_d;
      end
   end

   // edge synchronisers
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         {ref_m_q, ref_s_q, ref_p_q} <= 3'h0;
         {vco_m_q, vco_s_q, vco_p_q} <= 3'h0;
      end else begin
         {ref_m_q, ref_s_q, ref_p_q} <= {i_ref_div, ref_m_q, ref_s_q};
         {vco_m_q, vco_s_q, vco_p_q} <= {i_vco_div, vco_m_q, vco_s_q};
      end
   end
   assign ref_rise = ref_s_q & ~ref_p_q;
   assign vco_rise = vco_s_q & ~vco_p_q;

   // ring oscillator timer and window geometry
   always_comb begin
      test     = win_q[`PLD_WIN_TEST] && (sel_q == `PLD_TEST_RING);
      w_act    = en_q[`PLD_EN_WIN] && !test;
      ro_pm1   = 3'((4'h1 << win_q[`PLD_WIN_SPD]) - 4'h1);
      ro_tick  = (ro_cnt_q == ro_pm1);
      ro_cnt_d = ro_tick ? 3'h0 : ro_cnt_q + 3'h1;
      ro_d     = ro_tick ? ~ro_q : ro_q;
      half_i   = win_q[`PLD_WIN_SRC] ?
                 int'(win_q[`PLD_WIN_PW]) * (int'(ro_pm1) + 1) :
                 AWIN_CYC;
      cen_i    = 0;
      if (ofs_q[`PLD_OFS_EN]) begin
         cen_i = ofs_q[`PLD_OFS_AFT] ? OFFSET_CYC : -OFFSET_CYC;
      end
      close_i  = (cen_i + half_i < 0) ? 0 : cen_i + half_i;
      lo_i     = close_i - (cen_i + half_i);
      hi_i     = close_i - (cen_i - half_i);
      sr_d     = ref_rise ? '0 : sat_inc(sr_q);
      sv_d     = vco_rise ? '0 : sat_inc(sv_q);
      eval     = (pend_q | ref_rise) && (sr_d == CW'(close_i));
      pend_d   = ref_rise ? !eval : pend_q && !eval;
      hit      = (int'(sv_d) >= lo_i) && (int'(sv_d) <= hi_i);
   end

   // window lock counter
   always_comb begin
      wcnt_d  = wcnt_q;
      wlock_d = wlock_q;
      if (!w_act) begin
         wcnt_d  = 16'h0;
         wlock_d = 1'b0;
      end else if (eval) begin
         if (!hit) begin
            wcnt_d  = 16'h0;
            wlock_d = 1'b0;
         end else if (wcnt_q < win_q[`PLD_WIN_OK]) begin
            wcnt_d  = wcnt_q + 16'h1;
            wlock_d = (wcnt_d >= win_q[`PLD_WIN_OK]);
         end else begin
            wlock_d = 1'b1;
         end
      end
   end

   // phase error lock counter
   always_comb begin
      perr    = (sr_d > CW'(7'h7f)) ? 7'h7f : 7'(sr_d);
      p_in    = (perr >= ph_q[`PLD_PH_LO]) &&
                (perr <= ph_q[`PLD_PH_HI]);
      pcnt_d  = pcnt_q;
      plock_d = plock_q;
      if (!en_q[`PLD_EN_PH]) begin
         pcnt_d  = 10'h0;
         plock_d = 1'b0;
      end else if (vco_rise) begin
         if (!p_in) begin
            pcnt_d  = 10'h0;
            plock_d = 1'b0;
         end else if (pcnt_q < ph_q[`PLD_PH_OK]) begin
            pcnt_d  = pcnt_q + 10'h1;
            plock_d = (pcnt_d >= ph_q[`PLD_PH_OK]);
         end else begin
            plock_d = 1'b1;
         end
      end
   end

   // outputs
   always_comb begin
      lock_ind = en_q[`PLD_EN_OUT] && (wlock_q || plock_q);
      mp_d     = test ? ro_q : lock_ind;
      pump_o_d.boost = pump_q[`PLD_PUMP_BST];
      pump_o_d.up_ua = 13'(pump_q[`PLD_PUMP_UP] * `PLD_STEP_UA);
      pump_o_d.dn_ua = 13'(pump_q[`PLD_PUMP_DN] * `PLD_STEP_UA);
      if (pump_q[`PLD_PUMP_BST]) begin
         pump_o_d.up_ua = pump_o_d.up_ua + `PLD_BOOST_UA;
         pump_o_d.dn_ua = pump_o_d.dn_ua + `PLD_BOOST_UA;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sr_q     <= '1;
         sv_q     <= '1;
         pend_q   <= 1'b0;
         ro_cnt_q <= 3'h0;
         ro_q     <= 1'b0;
         wcnt_q   <= 16'h0;
         wlock_q  <= 1'b0;
         pcnt_q   <= 10'h0;
         plock_q  <= 1'b0;
         lock_q   <= 1'b0;
         mp_q     <= 1'b0;
         pump_o_q <= '0;
      end else begin
         sr_q     <= sr_d;
         sv_q     <= sv_d;
         pend_q   <= pend_d;
         ro_cnt_q <= ro_cnt_d;
         ro_q     <= ro_d;
         wcnt_q   <= wcnt_d;
         wlock_q  <= wlock_d;
         pcnt_q   <= pcnt_d;
         plock_q  <= plock_d;
         lock_q   <= lock_ind;
         mp_q     <= mp_d;
         pump_o_q <= pump_o_d;
      end
   end
   assign o_rdata  = rdata_q;
   assign o_lock   = lock_q;
   assign o_mp_pin = mp_q;
   assign o_pump   = pump_o_q;

   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   AST_BOOST: assert property (pump_q[`PLD_PUMP_BST] |=>
      o_pump.up_ua == 13'($past(pump_q[6:0]) * 20 + 3500))
      else $error("boost current not added");
   AST_BOOST_ZERO: assert property (
      pump_q[`PLD_PUMP_BST] && pump_q[6:0] == 7'h0 |=>
      o_pump.up_ua == 13'd3500 && o_pump.boost)
      else $error("boost alone wrong");
   AST_WIN_ENABLE: assert property (!en_q[`PLD_EN_WIN] |=> !wlock_q)
      else $error("window lock while disabled");
   AST_STATUS: assert property (
      i_bus.re && i_bus.addr == `PLD_A_STATUS |=> o_rdata[2] == o_lock)
      else $error("status and pin disagree");
   AST_ANALOG: assert property (
      eval && !win_q[22] && !ofs_q[0] |-> hit == (sv_d <= CW'(2)))
      else $error("analog window wrong");
   AST_DIGITAL: assert property (win_q[22] |->
      half_i == int'(win_q[18:16]) * (1 << win_q[20:19]))
      else $error("digital window wrong");
   AST_TEST: assert property (test |=> !wlock_q ##0
      o_mp_pin == $past(ro_q)) else $error("ring test mode wrong");
   AST_LOCK_CNT: assert property ($rose(wlock_q) |->
      wcnt_q >= win_q[15:0] && $past(eval) && $past(hit))
      else $error("lock before count");
   AST_RO_STATUS: assert property (i_bus.we && i_bus.addr ==
      `PLD_A_STATUS && !eval |=> $stable(wlock_q))
      else $error("status changed by write");
   AST_MISS: assert property (eval && w_act && !hit |=>
      !wlock_q && wcnt_q == 16'h0) else $error("miss did not clear");
   AST_AFTER: assert property (ofs_q == 2'h3 |->
      close_i == OFFSET_CYC + half_i) else $error("after offset wrong");
   AST_BEFORE: assert property (ofs_q == 2'h1 |->
      lo_i + hi_i == 2 * (close_i + OFFSET_CYC))
      else $error("before offset wrong");
   AST_PH_MISS: assert property (en_q[7] && vco_rise && !p_in |=>
      !plock_q && pcnt_q == 10'h0) else $error("phase miss kept");
   AST_PH_LOCK: assert property ($rose(plock_q) |->
      pcnt_q >= ph_q[23:14]) else $error("phase lock early");
   AST_HOLD: assert property (wlock_q && w_act && !eval |=>
      $stable(wcnt_q)) else $error("count moved while locked");
   // the pin flop and the status bit come from one lock source
   AST_LOCK_GATE: assert property (!en_q[`PLD_EN_OUT] |=> !o_lock)
      else $error("lock shown while output disabled");
   COV_WLOCK: cover property ($rose(wlock_q));
   COV_UNLOCK: cover property (wlock_q ##1 !wlock_q);
   COV_PLOCK: cover property ($rose(plock_q));
   COV_RING: cover property (test ##1 $changed(o_mp_pin));
   COV_PMISS: cover property (plock_q ##1 !plock_q);
endmodule // pld_lock_detector

// ==== pld_edge_source.sv ====
// Purpose: reference and divided oscillator edge source for the bench
// Assumes: one comparison period is PERIOD clocks, reference at clock 10
// Notes:   skew is oscillator edge minus reference edge, in clocks
`timescale 1ns/1ps
module pld_edge_source #(
   parameter int PERIOD = 40 // clocks per comparison
) (
   input  wire logic i_clock, // bench clock
   output logic      o_ref,   // reference divider pin
   output logic      o_vco    // divided oscillator pin
);
   localparam int TREF = 10;
   initial begin
      o_ref = 1'b0;
      o_vco = 1'b0;
   end
   // pins stay low between pulses, so no stale level is seen as an edge
   task automatic fire(input int skew);
      for (int k = 0; k < PERIOD; k++) begin
         @(posedge i_clock);
         o_ref <= (k >= TREF) && (k < TREF + 4);
         o_vco <= (k >= TREF + skew) && (k < TREF + skew + 4);
      end
   endtask
endmodule // pld_edge_source

// ==== pld_lock_detector_tb.sv ====
// Purpose: self-checking bench for the lock detector
// Assumes: OFFSET_CYC default of 2, analog window of one clock each side
// Notes:   register calls and edge bursts with expected values
`timescale 1ns/1ps
`include "pld_lock_regs.svh"
module pld_lock_detector_tb;
   import pld_pkg::*;
   logic         i_clock;
   logic         i_arst_n;
   pld_bus_type  bus;
   logic [31:0]  rdata;
   logic         ref_pin;
   logic         vco_pin;
   logic         lock;
   logic         mp_pin;
   pld_pump_type pump;
   int           n_fail;
   int           checked;
   int           cycles;
   int           tog;
   logic         prev;

   pld_lock_detector u_pld_lock_detector (
      .i_clock   (i_clock),
      .i_arst_n  (i_arst_n),
      .i_bus     (bus),
      .o_rdata   (rdata),
      .i_ref_div (ref_pin),
      .i_vco_div (vco_pin),
      .o_lock    (lock),
      .o_mp_pin  (mp_pin),
      .o_pump    (pump)
   );
   pld_edge_source u_pld_edge_source (
      .i_clock (i_clock),
      .o_ref   (ref_pin),
      .o_vco   (vco_pin)
   );

   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(logic [6:0] a, logic [31:0] d);
      @(posedge i_clock);
      bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(posedge i_clock);
      bus.we <= 1'b0;
   endtask

   task automatic rdc(logic [6:0] a, logic [31:0] exp, string name);
      @(posedge i_clock);
      bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
      @(posedge i_clock);
      bus.re <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask

   // one comparison cycle, then lock and pin both against expectation
   task automatic fire_chk(int skew, logic e);
      u_pld_edge_source.fire(skew);
      #1;
      chk("lock_pin", {30'h0, e, e}, {30'h0, lock, mp_pin});
   endtask

   function automatic logic [31:0] pexp(logic b, logic [12:0] u,
                                        logic [12:0] d);
      logic [12:0] add;
      add = b ? 13'hdac : 13'h000;
      return {5'h00, b, u * 13'h014 + add, d * 13'h014 + add};
   endfunction

   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      logic [6:0] regs [7];
      regs = '{`PLD_A_ENABLE, `PLD_A_PUMP, `PLD_A_OFFSET, `PLD_A_PHASE,
               `PLD_A_WINDOW, `PLD_A_TESTSEL, 7'h02};
      i_arst_n = 1'b0;
      bus = '0;
      n_fail = 0;
      checked = 0;
      cycles = 0;
      repeat (20) @(posedge i_clock);
      i_arst_n <= 1'b1;
      foreach (regs[i]) rdc(regs[i], 32'h0, "reset_value");
      wr(`PLD_A_STATUS, 32'hffffffff);
      rdc(`PLD_A_STATUS, 32'h0, "status_ro");
      $display("test registers done");
      wr(`PLD_A_PUMP, 32'h000185);
      repeat (2) @(posedge i_clock);
      #1 chk("pump", pexp(1'b0, 13'h005, 13'h003), {5'h00, pump});
      wr(`PLD_A_PUMP, 32'h800000);
      repeat (2) @(posedge i_clock);
      #1 chk("pump", pexp(1'b1, 13'h000, 13'h000), {5'h00, pump});
      wr(`PLD_A_PUMP, 32'h800185);
      repeat (2) @(posedge i_clock);
      #1 chk("pump", pexp(1'b1, 13'h005, 13'h003), {5'h00, pump});
      rdc(`PLD_A_PUMP, 32'h800185, "pump_reg");
      $display("test pump done");
      wr(`PLD_A_WINDOW, 32'h000001);
      fire_chk(0, 1'b0);
      wr(`PLD_A_ENABLE, 32'h000140);
      fire_chk(0, 1'b1);
      wr(`PLD_A_WINDOW, 32'h000003);
      fire_chk(2, 1'b0);
      fire_chk(-1, 1'b0);
      fire_chk(1, 1'b0);
      fire_chk(0, 1'b1);
      fire_chk(0, 1'b1);
      rdc(`PLD_A_STATUS, 32'h5, "status_lock");
      wr(`PLD_A_STATUS, 32'h0);
      rdc(`PLD_A_STATUS, 32'h5, "status_ro_lock");
      fire_chk(6, 1'b0);
      fire_chk(0, 1'b0);
      fire_chk(0, 1'b0);
      $display("test analog count done");
      wr(`PLD_A_WINDOW, 32'h000001);
      wr(`PLD_A_OFFSET, 32'h3);
      fire_chk(2, 1'b1);
      fire_chk(-2, 1'b0);
      wr(`PLD_A_OFFSET, 32'h1);
      fire_chk(-2, 1'b1);
      fire_chk(2, 1'b0);
      $display("test offset done");
      wr(`PLD_A_OFFSET, 32'h0);
      wr(`PLD_A_WINDOW, 32'h4a0001);
      fire_chk(4, 1'b1);
      fire_chk(5, 1'b0);
      fire_chk(-4, 1'b1);
      fire_chk(3, 1'b1);
      $display("test digital window done");
      wr(`PLD_A_TESTSEL, 32'hc1);
      wr(`PLD_A_WINDOW, 32'h6a0001);
      u_pld_edge_source.fire(0);
      #1 chk("lock", 32'h0, {31'h0, lock});
      tog = 0;
      prev = mp_pin;
      repeat (16) begin
         @(posedge i_clock);
         #1 if (mp_pin !== prev) tog++;
         prev = mp_pin;
      end
      chk("ring_pin", 32'h1, {31'h0, tog > 0});
      rdc(`PLD_A_STATUS, 32'h0, "status_test");
      wr(`PLD_A_TESTSEL, 32'h0);
      $display("test ring mode done");
      wr(`PLD_A_WINDOW, 32'h0);
      wr(`PLD_A_ENABLE, 32'h000180);
      wr(`PLD_A_PHASE, 32'h004281);
      u_pld_edge_source.fire(2);
      u_pld_edge_source.fire(2);
      rdc(`PLD_A_STATUS, 32'h6, "status_phase");
      $display("test phase done");
      stop_test();
   end
endmodule // pld_lock_detector_tb
